// >>> inc/ccpm_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ccpm_flag_if #(parameter int W = 8);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;
  modport owner (output set, output clr, input q);
  modport flags (input set, input clr, output q);
endinterface
`default_nettype wire

// >>> inc/ccpm_pkg.sv
`default_nettype none
package ccpm_pkg;
  localparam int CW = 8;
  localparam int DW = 32;
  localparam int ERR_W = 8;
  localparam int LOW_FLAGS = 5;
  localparam int OPT_W = 8;
  localparam int SW_W = 2;
  localparam int CNT_W = 2;
  localparam int OVR_N = 3;

  localparam logic [CW-1:0] CODE_INPUT3   = 8'h75;
  localparam logic [CW-1:0] CODE_INPUT1   = 8'h76;
  localparam logic [CW-1:0] CODE_INPUT2   = 8'h77;
  localparam logic [CW-1:0] CODE_PV       = 8'h78;
  localparam logic [CW-1:0] CODE_RV       = 8'h79;
  localparam logic [CW-1:0] CODE_TRIPLE   = 8'h7a;
  localparam logic [CW-1:0] CODE_OVR_OUT  = 8'h7b;
  localparam logic [CW-1:0] CODE_OVR_CSP  = 8'h7d;
  localparam logic [CW-1:0] CODE_SW_TYPE  = 8'h9d;
  localparam logic [CW-1:0] CODE_SW_VER   = 8'ha7;
  localparam logic [CW-1:0] CODE_OPTION   = 8'hb9;
  localparam logic [CW-1:0] CODE_SWITCH   = 8'hbe;
  localparam logic [CW-1:0] CODE_ERRSTAT  = 8'hff;
  localparam logic [CW-1:0] ANALOG_FIRST  = 8'h01;
  localparam logic [CW-1:0] ANALOG_LAST   = 8'h72;
  localparam logic [CW-1:0] DIGITAL_FIRST = 8'h80;
  localparam logic [CW-1:0] DIGITAL_LAST  = 8'hfa;

  localparam int EB_EMERG   = 0;
  localparam int EB_FAILSAF = 1;
  localparam int EB_CALSUM  = 2;
  localparam int EB_CFGSUM  = 3;
  localparam int EB_LIMIT   = 4;
  localparam int EB_HWFAIL  = 5;
  localparam int EB_RESTART = 6;
  localparam int EB_MEMCHG  = 7;

  localparam logic [OPT_W-1:0] OPT_WR_MASK = 8'h03;
  localparam logic [OPT_W-1:0] OPT_RESET   = 8'h03;
  localparam logic [DW-1:0]    BYTE_MAX    = 32'h0000_00ff;
  localparam logic [CNT_W-1:0] CNT_ONE     = 2'h1;
  localparam logic [CNT_W-1:0] CNT_TRIPLE  = 2'h3;

  typedef enum {
    K_READBACK, K_TRIPLE, K_OVERRIDE, K_RO_ID, K_OPTION,
    K_ERRSTAT, K_ANALOG, K_DIGITAL, K_OTHER
  } ccpm_kind_e;

  function automatic ccpm_kind_e ccpm_classify(input logic [CW-1:0] code,
                                               input logic wr);
    ccpm_kind_e k;
    k = K_OTHER;
    if (wr && (code == CODE_PV || code == CODE_OVR_OUT || code == CODE_OVR_CSP))
      k = K_OVERRIDE;
    else if (!wr && (code == CODE_OVR_OUT || code == CODE_OVR_CSP))
      k = K_OVERRIDE;
    else if (code == CODE_TRIPLE)
      k = K_TRIPLE;
    else if (code >= CODE_INPUT3 && code <= CODE_RV)
      k = K_READBACK;
    else if (code == CODE_SW_TYPE || code == CODE_SW_VER || code == CODE_SWITCH)
      k = K_RO_ID;
    else if (code == CODE_OPTION)
      k = K_OPTION;
    else if (code == CODE_ERRSTAT)
      k = K_ERRSTAT;
    else if (code >= ANALOG_FIRST && code <= ANALOG_LAST)
      k = K_ANALOG;
    else if (code >= DIGITAL_FIRST && code <= DIGITAL_LAST)
      k = K_DIGITAL;
    return k;
  endfunction

  function automatic logic [1:0] ccpm_ovr_index(input logic [CW-1:0] code);
    logic [1:0] i;
    i = 2'h0;
    if (code == CODE_OVR_OUT)
      i = 2'h1;
    else if (code == CODE_OVR_CSP)
      i = 2'h2;
    return i;
  endfunction
endpackage
`default_nettype wire

// >>> rtl/ccpm_change.sv
`timescale 1ns/1ps
`default_nettype none
module ccpm_change #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic         chg
);
  logic [W-1:0] prev;
  logic         armed;

  // The first cycle after reset is not compared, since prev holds no real history yet.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev  <= '0;
      armed <= 1'b0;
    end
    else
    begin
      prev  <= d;
      armed <= 1'b1;
    end
  end

  always_comb
  begin
    chg = armed && (d != prev);
  end
endmodule
`default_nettype wire

// >>> rtl/ccpm_param_map.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - An accepted write to an analog code in the writable range starts a memory write at once.
// - Override values are kept only in volatile registers and need slave mode.
// - An accepted write to a digital configuration code updates memory at once.
// - A write to a control-data readback code other than the process value changes nothing and gets an error answer.
// - Reads of the inputs, process value and remote value return one value in chosen units.
// - A read of the combined code returns process value, setpoint and output.
// - A read of the option status returns a value from 0 to 255 of option bits.
// - A write of the option status changes only its two lowest bits.
// - Software type, version and switch status are read only and refuse writes.
// - A read of the software type returns the fixed SW_TYPE parameter value.
// - A read of the switch status returns 0 to 3 with weight 1 for switch 1 and 2 for switch 2.
// - A read of the error status returns the bit-weighted flags with the given weights.
// - Any write to the error status clears the restart and memory-changed flags.
// - Memory-changed is set by shed, configuration or calibration change, or a low flag change.
module ccpm_param_map
  import ccpm_pkg::*;
#(
  parameter logic [OPT_W-1:0] SW_TYPE    = 8'h00,  // Arbitrary identity value.
  parameter logic [OPT_W-1:0] SW_VERSION = 8'h00   // Arbitrary identity value.
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [CW-1:0]     req_code,
  input  wire logic [DW-1:0]     req_data,
  input  wire logic [DW-1:0]     input_one,
  input  wire logic [DW-1:0]     input_two,
  input  wire logic [DW-1:0]     input_three,
  input  wire logic [DW-1:0]     process_value,
  input  wire logic [DW-1:0]     remote_value,
  input  wire logic [DW-1:0]     setpoint_value,
  input  wire logic [DW-1:0]     output_value,
  input  wire logic              comm_units_eng,
  input  wire logic              slave_mode,
  input  wire logic [OPT_W-1:0]  options_installed,
  input  wire logic [SW_W-1:0]   switch_closed,
  input  wire logic              emergency_manual,
  input  wire logic              failsafe,
  input  wire logic              param_limit,
  input  wire logic              hardware_failure,
  input  wire logic              cal_cksum_fail,
  input  wire logic              cfg_cksum_fail,
  input  wire logic              cksum_recomputed,
  input  wire logic              shed_event,
  input  wire logic              config_changed,
  input  wire logic              calib_changed,
  output logic                   rsp_valid,
  output logic                   rsp_error,
  output logic                   rsp_units_eng,
  output logic [CNT_W-1:0]       rsp_count,
  output logic [DW-1:0]          rsp_data,
  output logic [DW-1:0]          rsp_data2,
  output logic [DW-1:0]          rsp_data3,
  output logic                   nvm_write_stb,
  output logic [CW-1:0]          nvm_code,
  output logic [DW-1:0]          nvm_data,
  output logic [DW-1:0]          ovr_pv,
  output logic [DW-1:0]          ovr_out,
  output logic [DW-1:0]          ovr_csp,
  output logic [OVR_N-1:0]       ovr_valid,
  output logic [1:0]             input3_enable,
  output logic [ERR_W-1:0]       error_status
);
  ccpm_flag_if #(.W(ERR_W)) eflags ();
  ccpm_kind_e       kind;
  logic             wr_ok;
  logic             low_chg;
  logic             errstat_wr;
  logic [1:0]       oidx;
  logic [DW-1:0]    ovr_mem [OVR_N];
  logic [1:0]       opt_bits;
  logic             next_err;
  logic [CNT_W-1:0] next_cnt;
  logic [DW-1:0]    next_d1;
  logic [DW-1:0]    next_d2;
  logic [DW-1:0]    next_d3;

  ccpm_sticky #(.W(ERR_W)) u_sticky (
    .clk   (clk),
    .rst_n (rst_n),
    .f     (eflags.flags)
  );

  ccpm_change #(.W(LOW_FLAGS)) u_change (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (eflags.q[LOW_FLAGS-1:0]),
    .chg   (low_chg)
  );

  always_comb
  begin
    kind       = ccpm_classify(req_code, req_write);
    oidx       = ccpm_ovr_index(req_code);
    errstat_wr = req_valid && req_write && kind == K_ERRSTAT;
  end

  // Level conditions follow their inputs; sticky ones are set by events.
  always_comb
  begin
    eflags.set = '0;
    eflags.clr = '0;
    eflags.set[EB_EMERG]   = emergency_manual;
    eflags.set[EB_FAILSAF] = failsafe;
    eflags.set[EB_LIMIT]   = param_limit;
    eflags.set[EB_HWFAIL]  = hardware_failure;
    eflags.clr[EB_EMERG]   = !emergency_manual;
    eflags.clr[EB_FAILSAF] = !failsafe;
    eflags.clr[EB_LIMIT]   = !param_limit;
    eflags.clr[EB_HWFAIL]  = !hardware_failure;
    eflags.set[EB_CALSUM]  = cal_cksum_fail;
    eflags.set[EB_CFGSUM]  = cfg_cksum_fail;
    eflags.clr[EB_CALSUM]  = cksum_recomputed;
    eflags.clr[EB_CFGSUM]  = cksum_recomputed;
    eflags.set[EB_RESTART] = shed_event;
    eflags.set[EB_MEMCHG]  = shed_event || config_changed || calib_changed || low_chg;
    eflags.clr[EB_RESTART] = errstat_wr;
    eflags.clr[EB_MEMCHG]  = errstat_wr;
  end

  // Request decode: answer data, count and error flag for the next cycle.
  always_comb
  begin
    next_err = 1'b0;
    next_cnt = CNT_ONE;
    next_d1  = '0;
    next_d2  = '0;
    next_d3  = '0;
    wr_ok    = 1'b0;
    case (kind)
      K_READBACK:
      begin
        if (req_write)
          next_err = 1'b1;
        else if (req_code == CODE_INPUT1)
          next_d1 = input_one;
        else if (req_code == CODE_INPUT2)
          next_d1 = input_two;
        else if (req_code == CODE_INPUT3)
          next_d1 = input_three;
        else if (req_code == CODE_PV)
          next_d1 = process_value;
        else
          next_d1 = remote_value;
      end
      K_TRIPLE:
      begin
        next_err = req_write;
        next_cnt = CNT_TRIPLE;
        next_d1  = process_value;
        next_d2  = setpoint_value;
        next_d3  = output_value;
      end
      K_OVERRIDE:
      begin
        if (req_write)
        begin
          next_err = !slave_mode;
          wr_ok    = slave_mode;
        end
        next_d1 = ovr_mem[oidx];
      end
      K_RO_ID:
      begin
        next_err = req_write;
        if (req_code == CODE_SW_TYPE)
          next_d1 = {{(DW-OPT_W){1'b0}}, SW_TYPE};
        else if (req_code == CODE_SW_VER)
          next_d1 = {{(DW-OPT_W){1'b0}}, SW_VERSION};
        else
          next_d1 = {{(DW-SW_W){1'b0}}, switch_closed};
      end
      K_OPTION:
      begin
        if (req_write)
        begin
          next_err = req_data > BYTE_MAX;
          wr_ok    = req_data <= BYTE_MAX;
        end
        next_d1 = {{(DW-OPT_W){1'b0}}, options_installed[OPT_W-1:2], opt_bits};
      end
      K_ERRSTAT:
      begin
        wr_ok   = req_write;
        next_d1 = {{(DW-ERR_W){1'b0}}, eflags.q};
      end
      K_ANALOG, K_DIGITAL:
      begin
        next_err = !req_write;
        wr_ok    = req_write;
      end
      default:
      begin
        next_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid     <= 1'b0;
      rsp_error     <= 1'b0;
      rsp_units_eng <= 1'b0;
      rsp_count     <= '0;
      rsp_data      <= '0;
      rsp_data2     <= '0;
      rsp_data3     <= '0;
    end
    else
    begin
      rsp_valid     <= req_valid;
      rsp_error     <= req_valid && next_err;
      rsp_units_eng <= comm_units_eng;
      rsp_count     <= req_valid ? next_cnt : '0;
      rsp_data      <= req_valid ? next_d1 : '0;
      rsp_data2     <= req_valid ? next_d2 : '0;
      rsp_data3     <= req_valid ? next_d3 : '0;
    end
  end

  // Overrides never reach the memory strobe, so they cost no retention wear.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nvm_write_stb <= 1'b0;
      nvm_code      <= '0;
      nvm_data      <= '0;
    end
    else
    begin
      nvm_write_stb <= req_valid && wr_ok && (kind == K_ANALOG || kind == K_DIGITAL
                       || kind == K_OPTION);
      if (req_valid && wr_ok)
      begin
        nvm_code <= req_code;
        nvm_data <= req_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      opt_bits <= OPT_RESET[1:0];
    else if (req_valid && wr_ok && kind == K_OPTION)
      opt_bits <= req_data[1:0] & OPT_WR_MASK[1:0];
  end

  // Leaving slave mode clears every ovr_valid bit; ovr_mem, its outputs and its reads keep the last values.
  genvar gi;
  generate
    for (gi = 0; gi < OVR_N; gi++)
    begin : g_ovr
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          ovr_mem[gi]   <= '0;
          ovr_valid[gi] <= 1'b0;
        end
        else if (!slave_mode)
          ovr_valid[gi] <= 1'b0;
        else if (req_valid && wr_ok && kind == K_OVERRIDE && oidx == gi)
        begin
          ovr_mem[gi]   <= req_data;
          ovr_valid[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  always_comb
  begin
    ovr_pv        = ovr_mem[0];
    ovr_out       = ovr_mem[1];
    ovr_csp       = ovr_mem[2];
    input3_enable = opt_bits;
    error_status  = eflags.q;
  end

  a_readback_wr_err: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_write && (kind == K_READBACK || kind == K_TRIPLE)
    |=> rsp_valid && rsp_error && !nvm_write_stb)
    else $error("readback write not refused");
  a_analog_nvm_start: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_write && kind == K_ANALOG
    |=> nvm_write_stb && nvm_code == $past(req_code) && !rsp_error)
    else $error("analog write did not start memory write");
  a_digital_nvm_start: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_write && kind == K_DIGITAL |=> nvm_write_stb && nvm_data == $past(req_data))
    else $error("digital write did not update memory");
  a_override_volatile: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_write && kind == K_OVERRIDE
    |=> !nvm_write_stb && (rsp_error == !$past(slave_mode)))
    else $error("override write handled wrongly");
  a_single_value_read: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && !req_write && req_code == CODE_INPUT1 |=> rsp_count == CNT_ONE
    && rsp_data == $past(input_one))
    else $error("single read returned wrong value");
  a_triple_response: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && !req_write && kind == K_TRIPLE |=> rsp_count == CNT_TRIPLE
    && rsp_data2 == $past(setpoint_value) && rsp_data3 == $past(output_value))
    else $error("triple response wrong");
  a_option_range: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && !req_write && kind == K_OPTION |=> rsp_data <= BYTE_MAX)
    else $error("option status out of range");
  a_option_limited: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_write && kind == K_OPTION && req_data <= BYTE_MAX
    |=> input3_enable == $past(req_data[1:0]))
    else $error("option write not limited to low bits");
  a_ro_id_refused: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_write && kind == K_RO_ID |=> rsp_error && !nvm_write_stb)
    else $error("read-only write accepted");
  a_sw_type_read: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && !req_write && req_code == CODE_SW_TYPE |=> rsp_data[OPT_W-1:0] == SW_TYPE)
    else $error("software type wrong");
  a_switch_read: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && !req_write && req_code == CODE_SWITCH |=> rsp_data == $past(switch_closed))
    else $error("switch status wrong");
  a_errstat_read: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && !req_write && kind == K_ERRSTAT |=> rsp_data == $past(error_status))
    else $error("error status read wrong");
  a_errstat_clear: assert property (@(posedge clk) disable iff (!rst_n)
    errstat_wr && !shed_event |=> !error_status[EB_RESTART])
    else $error("restart flag not cleared");
  a_memchg_set: assert property (@(posedge clk) disable iff (!rst_n)
    shed_event || config_changed || calib_changed |=> error_status[EB_MEMCHG])
    else $error("memory changed flag not set");
  a_level_sum: assert property (@(posedge clk) disable iff (!rst_n)
    failsafe && hardware_failure |=> error_status[EB_FAILSAF] && error_status[EB_HWFAIL])
    else $error("concurrent flags not both shown");
  a_cksum_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    error_status[EB_CFGSUM] && !cksum_recomputed |=> error_status[EB_CFGSUM])
    else $error("checksum flag lost");

  c_triple_read: cover property (@(posedge clk) disable iff (!rst_n)
    req_valid && !req_write && kind == K_TRIPLE);
  c_errstat_clear: cover property (@(posedge clk) disable iff (!rst_n)
    error_status[EB_RESTART] ##1 errstat_wr);
  c_override_ok: cover property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_write && kind == K_OVERRIDE && slave_mode);
endmodule
`default_nettype wire

// >>> rtl/ccpm_sticky.sv
`timescale 1ns/1ps
`default_nettype none
module ccpm_sticky #(
  parameter int W = 8
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  ccpm_flag_if.flags  f
);
  // A set arriving in the same cycle as its clear wins, so no event is lost.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      f.q <= '0;
    else
      f.q <= (f.q & ~f.clr) | f.set;
  end
endmodule
`default_nettype wire

// >>> tb/ccpm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccpm_host_model
  import ccpm_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rsp_valid,
  input  wire logic             rsp_error,
  input  wire logic [CNT_W-1:0] rsp_count,
  input  wire logic [DW-1:0]    rsp_data,
  input  wire logic [DW-1:0]    rsp_data2,
  input  wire logic [DW-1:0]    rsp_data3,
  output logic                  req_valid,
  output logic                  req_write,
  output logic [CW-1:0]         req_code,
  output logic [DW-1:0]         req_data
);
  logic             got_ok;
  logic             got_err;
  logic [CNT_W-1:0] got_cnt;
  logic [DW-1:0]    got [3];

  initial
  begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_code  = 8'h00;
    req_data  = 32'h0000_0000;
  end

  // One request per call; the answer is taken one cycle after the request was driven.
  task automatic xfer(input logic wr, input logic [CW-1:0] code, input logic [DW-1:0] data);
    @(negedge clk);
    req_valid = 1'b1;
    req_write = wr;
    req_code  = code;
    req_data  = data;
    @(negedge clk);
    got_ok    = rsp_valid;
    got_err   = rsp_error;
    got_cnt   = rsp_count;
    got       = '{rsp_data, rsp_data2, rsp_data3};
    req_valid = 1'b0;
    // Idle lines are scrambled so a design that reads them outside a request is caught.
    req_write = ~wr;
    req_code  = ~code;
    req_data  = ~data;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ccpm_pkg::*;
  logic             clk;
  logic             rst_n;
  logic             req_valid, req_write, comm_units_eng, slave_mode;
  logic             emergency_manual, failsafe, param_limit, hardware_failure;
  logic             cal_cksum_fail, cfg_cksum_fail, cksum_recomputed;
  logic             shed_event, config_changed, calib_changed;
  logic             rsp_valid, rsp_error, rsp_units_eng, nvm_write_stb;
  logic [CW-1:0]    req_code, nvm_code;
  logic [DW-1:0]    req_data, input_one, input_two, input_three, process_value;
  logic [DW-1:0]    remote_value, setpoint_value, output_value, rsp_data, rsp_data2;
  logic [DW-1:0]    rsp_data3, nvm_data, ovr_pv, ovr_out, ovr_csp;
  logic [OPT_W-1:0] options_installed;
  logic [SW_W-1:0]  switch_closed;
  logic [CNT_W-1:0] rsp_count;
  logic [OVR_N-1:0] ovr_valid;
  logic [1:0]       input3_enable;
  logic [ERR_W-1:0] error_status;
  int               num_errors;
  int               checks_done;
  localparam logic [7:0] TYPE_ID = 8'h2a;  // Arbitrary identity value.
  localparam logic [7:0] VER_ID  = 8'h07;  // Arbitrary identity value.

  ccpm_param_map #(.SW_TYPE(TYPE_ID), .SW_VERSION(VER_ID)) dut (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
    .req_code(req_code), .req_data(req_data), .input_one(input_one),
    .input_two(input_two), .input_three(input_three), .process_value(process_value),
    .remote_value(remote_value), .setpoint_value(setpoint_value),
    .output_value(output_value), .comm_units_eng(comm_units_eng), .slave_mode(slave_mode),
    .options_installed(options_installed), .switch_closed(switch_closed),
    .emergency_manual(emergency_manual), .failsafe(failsafe), .param_limit(param_limit),
    .hardware_failure(hardware_failure), .cal_cksum_fail(cal_cksum_fail),
    .cfg_cksum_fail(cfg_cksum_fail), .cksum_recomputed(cksum_recomputed),
    .shed_event(shed_event), .config_changed(config_changed),
    .calib_changed(calib_changed), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_units_eng(rsp_units_eng), .rsp_count(rsp_count), .rsp_data(rsp_data),
    .rsp_data2(rsp_data2), .rsp_data3(rsp_data3), .nvm_write_stb(nvm_write_stb),
    .nvm_code(nvm_code), .nvm_data(nvm_data), .ovr_pv(ovr_pv), .ovr_out(ovr_out),
    .ovr_csp(ovr_csp), .ovr_valid(ovr_valid), .input3_enable(input3_enable),
    .error_status(error_status)
  );

  ccpm_host_model host (
    .clk(clk), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_count(rsp_count),
    .rsp_data(rsp_data), .rsp_data2(rsp_data2), .rsp_data3(rsp_data3),
    .req_valid(req_valid), .req_write(req_write), .req_code(req_code), .req_data(req_data)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic txn(input logic wr, input logic [CW-1:0] c, input logic [DW-1:0] d,
                     input logic err);
    host.xfer(wr, c, d);
    chk({host.got_ok, host.got_err}, {1'b1, err});
  endtask

  task automatic t_readback();
    logic [CW-1:0] c [5];
    logic [DW-1:0] v [5];
    c = '{CODE_INPUT1, CODE_INPUT2, CODE_INPUT3, CODE_PV, CODE_RV};
    v = '{input_one, input_two, input_three, process_value, remote_value};
    foreach (c[i])
    begin
      txn(1'b0, c[i], 32'h0, 1'b0);
      chk(host.got[0], v[i]);
      chk({rsp_units_eng, host.got_cnt}, {1'b1, CNT_ONE});
    end
    c = '{8'h75, 8'h76, 8'h77, 8'h79, 8'h7a};
    foreach (c[i])
    begin
      txn(1'b1, c[i], 32'h5, 1'b1);
      chk(nvm_write_stb, 1'b0);
    end
  endtask

  task automatic t_triple();
    comm_units_eng = 1'b0;
    txn(1'b0, CODE_TRIPLE, 32'h0, 1'b0);
    chk(rsp_units_eng, 1'b0);
    comm_units_eng = 1'b1;
    chk(host.got_cnt, 2'h3);
    chk(host.got[0], process_value);
    chk(host.got[1], setpoint_value);
    chk(host.got[2], output_value);
  endtask

  task automatic t_option();
    txn(1'b0, CODE_OPTION, 32'h0, 1'b0);
    chk(host.got[0], 32'ha7);
    txn(1'b1, CODE_OPTION, 32'h02, 1'b0);
    chk(input3_enable, 2'b10);
    txn(1'b0, CODE_OPTION, 32'h0, 1'b0);
    chk(host.got[0], 32'ha6);
    txn(1'b1, CODE_OPTION, 32'h100, 1'b1);
    chk(input3_enable, 2'b10);
  endtask

  task automatic t_readonly();
    logic [CW-1:0] c [3];
    logic [DW-1:0] v [3];
    switch_closed = 2'b10;
    c = '{CODE_SW_TYPE, CODE_SW_VER, CODE_SWITCH};
    v = '{TYPE_ID, VER_ID, 32'h2};
    foreach (c[i])
    begin
      txn(1'b1, c[i], 32'h1, 1'b1);
      txn(1'b0, c[i], 32'h0, 1'b0);
      chk(host.got[0], v[i]);
    end
    for (int s = 0; s < 4; s++)
    begin
      switch_closed = s[1:0];
      txn(1'b0, CODE_SWITCH, 32'h0, 1'b0);
      chk(host.got[0], 32'(s));
    end
  endtask

  task automatic t_nvm();
    logic [CW-1:0] c [4];
    c = '{8'h01, 8'h72, 8'h80, 8'hfa};
    foreach (c[i])
    begin
      txn(1'b1, c[i], 32'h5a5a_0000 | c[i], 1'b0);
      chk({nvm_write_stb, nvm_code}, {1'b1, c[i]});
      chk(nvm_data, 32'h5a5a_0000 | c[i]);
    end
    txn(1'b1, 8'h73, 32'h0, 1'b1);
    chk(nvm_write_stb, 1'b0);
  endtask

  task automatic t_override();
    slave_mode = 1'b1;
    txn(1'b1, 8'h78, 32'h11, 1'b0);
    txn(1'b1, CODE_OVR_OUT, 32'h22, 1'b0);
    txn(1'b1, CODE_OVR_CSP, 32'h33, 1'b0);
    chk(nvm_write_stb, 1'b0);
    chk(ovr_pv, 32'h11);
    chk(ovr_out, 32'h22);
    chk(ovr_csp, 32'h33);
    chk(ovr_valid, 3'b111);
    slave_mode = 1'b0;
    txn(1'b1, CODE_OVR_OUT, 32'h44, 1'b1);
    chk(ovr_valid, 3'b000);
  endtask

  task automatic t_errstat();
    emergency_manual = 1'b1;
    param_limit = 1'b1;
    tick(3);
    chk(error_status, 8'h91);
    txn(1'b0, CODE_ERRSTAT, 32'h0, 1'b0);
    chk(host.got[0], 32'h91);
    txn(1'b1, CODE_ERRSTAT, 32'hff, 1'b0);
    chk(error_status, 8'h11);
    emergency_manual = 1'b0;
    param_limit = 1'b0;
    failsafe = 1'b1;
    hardware_failure = 1'b1;
    tick(3);
    chk(error_status, 8'ha2);
    cal_cksum_fail = 1'b1;
    cfg_cksum_fail = 1'b1;
    tick(1);
    cal_cksum_fail = 1'b0;
    cfg_cksum_fail = 1'b0;
    txn(1'b1, CODE_ERRSTAT, 32'h0, 1'b0);
    chk(error_status, 8'h2e);
    pulse(cksum_recomputed);
    tick(2);
    chk(error_status, 8'ha2);
    txn(1'b1, CODE_ERRSTAT, 32'h0, 1'b0);
    pulse(shed_event);
    chk(error_status, 8'he2);
    txn(1'b1, CODE_ERRSTAT, 32'h0, 1'b0);
    pulse(config_changed);
    chk(error_status, 8'ha2);
    txn(1'b1, CODE_ERRSTAT, 32'h0, 1'b0);
    pulse(calib_changed);
    chk(error_status, 8'ha2);
    failsafe = 1'b0;
    hardware_failure = 1'b0;
    tick(3);
    txn(1'b1, CODE_ERRSTAT, 32'h0, 1'b0);
    txn(1'b0, CODE_ERRSTAT, 32'h0, 1'b0);
    chk(host.got[0], 32'h0);
  endtask

  task automatic end_of_test();
    $display("checks_done %0d num_errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    num_errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    {emergency_manual, failsafe, param_limit, hardware_failure} = 4'h0;
    {cal_cksum_fail, cfg_cksum_fail, cksum_recomputed, slave_mode} = 4'h0;
    {shed_event, config_changed, calib_changed} = 3'h0;
    comm_units_eng = 1'b1;
    options_installed = 8'ha4;
    switch_closed = 2'h0;
    input_one = 32'h0000_0101;
    input_two = 32'h0000_0202;
    input_three = 32'h0000_0303;
    process_value = 32'h0000_0404;
    remote_value = 32'h0000_0505;
    setpoint_value = 32'h0000_0606;
    output_value = 32'h0000_0707;
    tick(10);
    rst_n = 1'b1;
    chk({rsp_valid, nvm_write_stb, input3_enable, error_status}, {4'h3, 8'h00});
    t_readback();
    t_triple();
    t_option();
    t_readonly();
    t_nvm();
    t_override();
    t_errstat();
    // A reset in mid-run must restore the input 3 enables and forget the last write.
    rst_n = 1'b0;
    tick(2);
    chk({input3_enable, nvm_code, error_status}, {2'h3, 8'h00, 8'h00});
    rst_n = 1'b1;
    txn(1'b0, CODE_OPTION, 32'h0, 1'b0);
    chk(host.got[0], 32'ha7);
    end_of_test();
  end

  // The whole sequence needs about 115 cycles; 4000 cycles, some 35 times that, marks a hang.
  initial
  begin
    #(4000 * 50);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
